// ### hw/tmr8_channel.sv
// Function
// - nonzero output mode takes pin, direction enables
// - non-PWM modes: off, toggle, clear, set
// - fast PWM: off, reserved, non-inverting, inverting
// - fast PWM compare at top acts at bottom
// - phase PWM: direction-dependent clear/set on match
// - phase PWM compare at top acts at top
// - clock select: stop, direct, four prescaler taps
// - codes 110/111 count external falling/rising edges
// - external pin counts even when driven as output
// - counter read/write; write blocks next match
// - compare value continuously compared with counter
// - compare flag set on counter match
// - compare flag cleared by vector or one
// - overflow flag at overflow; phase PWM at bottom
// - overflow flag cleared by vector or one
// - compare request: flag, enable, global enable
// - overflow request: flag, enable, global enable
// - sync mode holds prescaler resets; clearing releases
// - shared prescaler reset self-clears unless sync mode
// - waveform mode: normal, phase PWM, CTC, fast
// - external pin synchronized and edge detected
//
// The plain strobed port was left to the implementer.
module tmr8_channel (
  input wire logic clk,
  input wire logic sys_rst,
  input tmr8_pkg::tmr8_bus_req_t busReq,
  output logic [7:0] busRdata,
  input wire logic cpuGlobalIrqEnable,
  input wire logic compareIrqAck,
  input wire logic overflowIrqAck,
  output tmr8_pkg::tmr8_irq_t irqReq,
  input wire logic externalCountPin,
  input wire logic portDirBit,
  output logic compareOutputPin,
  output logic compareOutputOverride,
  output logic compareOutputOe,
  output logic secondPrescalerReset
);

  tmr8_pkg::tmr8_state_t state_q;
  tmr8_pkg::tmr8_state_t state_d;

  tmr8_pkg::tmr8_wave_t wave;
  tmr8_pkg::tmr8_clksel_t clkSel;
  logic tick;
  logic extRise;
  logic extFall;
  logic atMax;
  logic atBottom;
  logic matchNow;
  logic compareAtTop;
  logic overflowEvent;
  logic [7:0] genCtrlRead;
  logic [7:0] ctrlRead;

  assign wave = tmr8_pkg::tmr8_wave_t'(state_q.waveMode);
  assign clkSel = tmr8_pkg::tmr8_clksel_t'(state_q.clockSelect);
  // only the second sync stage and its delayed copy feed the detector
  assign extRise = state_q.extSync2 & ~state_q.extPrev;
  assign extFall = ~state_q.extSync2 & state_q.extPrev;
  assign atMax = state_q.counterValue == tmr8_pkg::COUNT_MAX;
  assign atBottom = state_q.counterValue == tmr8_pkg::COUNT_BOTTOM;
  // one event term so any overflow, even onto a set flag, beats a clear
  assign overflowEvent = tick && (wave == tmr8_pkg::WAVE_PHASE_PWM ?
                                  state_q.countDown && atBottom : atMax);
  assign compareAtTop = state_q.compareValue == tmr8_pkg::COUNT_MAX;

  always_comb begin
    unique case (clkSel)
      tmr8_pkg::CS_STOPPED: tick = 1'b0;
      tmr8_pkg::CS_DIRECT: tick = 1'b1;
      tmr8_pkg::CS_DIV8: tick = (state_q.prescale & tmr8_pkg::TAP_DIV8) == tmr8_pkg::TAP_DIV8;
      tmr8_pkg::CS_DIV64: tick = (state_q.prescale & tmr8_pkg::TAP_DIV64) == tmr8_pkg::TAP_DIV64;
      tmr8_pkg::CS_DIV256: tick = (state_q.prescale & tmr8_pkg::TAP_DIV256) ==
                                  tmr8_pkg::TAP_DIV256;
      tmr8_pkg::CS_DIV1024: tick = (state_q.prescale & tmr8_pkg::TAP_DIV1024) ==
                                   tmr8_pkg::TAP_DIV1024;
      tmr8_pkg::CS_EXT_FALL: tick = extFall;
      tmr8_pkg::CS_EXT_RISE: tick = extRise;
    endcase
  end

  // a held prescaler reset also holds every tap low
  assign matchNow = tick && !state_q.blockMatch &&
                    state_q.counterValue == state_q.compareValue;

  always_comb begin
    genCtrlRead = tmr8_pkg::REG8_RESET;
    genCtrlRead[tmr8_pkg::GEN_SYNC_HOLD_BIT] = state_q.syncHoldMode;
    genCtrlRead[tmr8_pkg::GEN_SECOND_PSR_BIT] = state_q.secondPrescalerReset;
    genCtrlRead[tmr8_pkg::GEN_SHARED_PSR_BIT] = state_q.sharedPrescalerReset;
    ctrlRead = tmr8_pkg::REG8_RESET;
    ctrlRead[tmr8_pkg::CTRL_WAVE_LO_BIT] = state_q.waveMode[0];
    ctrlRead[tmr8_pkg::CTRL_WAVE_HI_BIT] = state_q.waveMode[1];
    ctrlRead[tmr8_pkg::CTRL_COM_HI_BIT] = state_q.compareOutputMode[1];
    ctrlRead[tmr8_pkg::CTRL_COM_LO_BIT] = state_q.compareOutputMode[0];
    ctrlRead[tmr8_pkg::CTRL_CS_HI_BIT -: 3] = state_q.clockSelect;
  end

  always_comb begin
    state_d = state_q;

    state_d.extSync1 = externalCountPin;
    state_d.extSync2 = state_q.extSync1;
    state_d.extPrev = state_q.extSync2;

    if (state_q.sharedPrescalerReset) begin
      state_d.prescale = tmr8_pkg::PRESCALE_RESET;
    end else begin
      state_d.prescale = state_q.prescale + 10'h001;
    end

    // prescaler reset bits last one cycle unless held by sync mode
    if (!state_q.syncHoldMode) begin
      state_d.sharedPrescalerReset = 1'b0;
      state_d.secondPrescalerReset = 1'b0;
    end

    if (tick) begin
      state_d.blockMatch = 1'b0;
      unique case (wave)
        tmr8_pkg::WAVE_PHASE_PWM: begin
          if (!state_q.countDown) begin
            if (atMax) begin
              state_d.countDown = 1'b1;
              state_d.counterValue = state_q.counterValue - 8'h01;
            end else begin
              state_d.counterValue = state_q.counterValue + 8'h01;
            end
          end else if (atBottom) begin
            state_d.countDown = 1'b0;
            state_d.counterValue = state_q.counterValue + 8'h01;
            state_d.overflowFlag = 1'b1;
          end else begin
            state_d.counterValue = state_q.counterValue - 8'h01;
          end
        end
        tmr8_pkg::WAVE_CLEAR_ON_MATCH: begin
          state_d.countDown = 1'b0;
          if (state_q.counterValue == state_q.compareValue) begin
            state_d.counterValue = tmr8_pkg::COUNT_BOTTOM;
          end else begin
            state_d.counterValue = state_q.counterValue + 8'h01;
          end
          if (atMax) begin
            state_d.overflowFlag = 1'b1;
          end
        end
        default: begin
          state_d.countDown = 1'b0;
          state_d.counterValue = state_q.counterValue + 8'h01;
          if (atMax) begin
            state_d.overflowFlag = 1'b1;
          end
        end
      endcase
    end

    if (matchNow) begin
      state_d.compareFlag = 1'b1;
    end

    if (state_q.compareOutputMode != 2'b00) begin
      unique case (wave)
        tmr8_pkg::WAVE_FAST_PWM: begin
          if (state_q.compareOutputMode[1]) begin
            if (matchNow && !compareAtTop) begin
              state_d.waveOut = state_q.compareOutputMode[0];
            end
            if (tick && atMax) begin
              state_d.waveOut = ~state_q.compareOutputMode[0];
            end
          end
        end
        tmr8_pkg::WAVE_PHASE_PWM: begin
          if (state_q.compareOutputMode[1]) begin
            if (compareAtTop) begin
              if (tick && atMax && !state_q.countDown) begin
                state_d.waveOut = ~state_q.compareOutputMode[0];
              end
            end else if (matchNow) begin
              state_d.waveOut = state_q.countDown ^ state_q.compareOutputMode[0];
            end
          end
        end
        default: begin
          if (matchNow) begin
            unique case (state_q.compareOutputMode)
              2'b01: state_d.waveOut = ~state_q.waveOut;
              2'b10: state_d.waveOut = 1'b0;
              default: state_d.waveOut = 1'b1;
            endcase
          end
        end
      endcase
    end

    // a hardware set in the same cycle beats either clear
    if (compareIrqAck && !matchNow) begin
      state_d.compareFlag = 1'b0;
    end
    if (overflowIrqAck && !overflowEvent) begin
      state_d.overflowFlag = 1'b0;
    end

    if (busReq.wr) begin
      unique case (busReq.addr)
        tmr8_pkg::GEN_TIMER_CTRL_OFS: begin
          state_d.syncHoldMode = busReq.wdata[tmr8_pkg::GEN_SYNC_HOLD_BIT];
          state_d.sharedPrescalerReset = busReq.wdata[tmr8_pkg::GEN_SHARED_PSR_BIT];
          state_d.secondPrescalerReset = busReq.wdata[tmr8_pkg::GEN_SECOND_PSR_BIT];
        end
        tmr8_pkg::TIMER_CTRL_OFS: begin
          state_d.waveMode = {busReq.wdata[tmr8_pkg::CTRL_WAVE_HI_BIT],
                              busReq.wdata[tmr8_pkg::CTRL_WAVE_LO_BIT]};
          state_d.compareOutputMode = busReq.wdata[tmr8_pkg::CTRL_COM_HI_BIT -: 2];
          state_d.clockSelect = busReq.wdata[tmr8_pkg::CTRL_CS_HI_BIT -: 3];
        end
        tmr8_pkg::COUNTER_VALUE_OFS: begin
          state_d.counterValue = busReq.wdata;
          state_d.blockMatch = 1'b1;
        end
        tmr8_pkg::COMPARE_VALUE_OFS: begin
          state_d.compareValue = busReq.wdata;
        end
        tmr8_pkg::IRQ_ENABLE_OFS: begin
          state_d.compareIrqEnable = busReq.wdata[tmr8_pkg::COMPARE_BIT];
          state_d.overflowIrqEnable = busReq.wdata[tmr8_pkg::OVERFLOW_BIT];
        end
        tmr8_pkg::IRQ_FLAG_OFS: begin
          // writing one clears, but a match in this cycle wins
          if (busReq.wdata[tmr8_pkg::COMPARE_BIT] && !matchNow) begin
            state_d.compareFlag = 1'b0;
          end
          if (busReq.wdata[tmr8_pkg::OVERFLOW_BIT] && !overflowEvent) begin
            state_d.overflowFlag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    state_d.rdata = tmr8_pkg::REG8_RESET;
    if (busReq.rd) begin
      unique case (busReq.addr)
        tmr8_pkg::GEN_TIMER_CTRL_OFS: state_d.rdata = genCtrlRead;
        tmr8_pkg::TIMER_CTRL_OFS: state_d.rdata = ctrlRead;
        tmr8_pkg::COUNTER_VALUE_OFS: state_d.rdata = state_q.counterValue;
        tmr8_pkg::COMPARE_VALUE_OFS: state_d.rdata = state_q.compareValue;
        tmr8_pkg::IRQ_ENABLE_OFS: begin
          state_d.rdata[tmr8_pkg::COMPARE_BIT] = state_q.compareIrqEnable;
          state_d.rdata[tmr8_pkg::OVERFLOW_BIT] = state_q.overflowIrqEnable;
        end
        tmr8_pkg::IRQ_FLAG_OFS: begin
          state_d.rdata[tmr8_pkg::COMPARE_BIT] = state_q.compareFlag;
          state_d.rdata[tmr8_pkg::OVERFLOW_BIT] = state_q.overflowFlag;
        end
        default: state_d.rdata = tmr8_pkg::REG8_RESET;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign busRdata = state_q.rdata;
  assign irqReq.compareReq = state_q.compareFlag & state_q.compareIrqEnable &
                             cpuGlobalIrqEnable;
  assign irqReq.overflowReq = state_q.overflowFlag & state_q.overflowIrqEnable &
                              cpuGlobalIrqEnable;
  assign compareOutputPin = state_q.waveOut;
  assign compareOutputOverride = |state_q.compareOutputMode;
  assign compareOutputOe = compareOutputOverride & portDirBit;
  assign secondPrescalerReset = state_q.secondPrescalerReset;

endmodule

// ### hw/tmr8_pkg.sv
package tmr8_pkg;

  // register offsets on the I/O register port
  localparam logic [7:0] GEN_TIMER_CTRL_OFS = 8'h23;
  localparam logic [7:0] TIMER_CTRL_OFS = 8'h24;
  localparam logic [7:0] COUNTER_VALUE_OFS = 8'h26;
  localparam logic [7:0] COMPARE_VALUE_OFS = 8'h27;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h28;
  localparam logic [7:0] IRQ_FLAG_OFS = 8'h29;

  // timer control field positions
  localparam int CTRL_WAVE_LO_BIT = 6;
  localparam int CTRL_COM_HI_BIT = 5;
  localparam int CTRL_COM_LO_BIT = 4;
  localparam int CTRL_WAVE_HI_BIT = 3;
  localparam int CTRL_CS_HI_BIT = 2;

  // general timer control field positions
  localparam int GEN_SYNC_HOLD_BIT = 7;
  localparam int GEN_SECOND_PSR_BIT = 1;
  localparam int GEN_SHARED_PSR_BIT = 0;

  // flag and enable field positions
  localparam int COMPARE_BIT = 1;
  localparam int OVERFLOW_BIT = 0;

  // values after reset
  localparam logic [7:0] REG8_RESET = 8'h00;
  localparam logic [9:0] PRESCALE_RESET = 10'h000;

  // counter limits
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;

  // prescaler tap masks: a tap fires when all masked bits are one
  localparam logic [9:0] TAP_DIV8 = 10'h007;
  localparam logic [9:0] TAP_DIV64 = 10'h03F;
  localparam logic [9:0] TAP_DIV256 = 10'h0FF;
  localparam logic [9:0] TAP_DIV1024 = 10'h3FF;

  typedef enum logic [1:0] {
    WAVE_NORMAL,
    WAVE_PHASE_PWM,
    WAVE_CLEAR_ON_MATCH,
    WAVE_FAST_PWM
  } tmr8_wave_t;

  typedef enum logic [2:0] {
    CS_STOPPED,
    CS_DIRECT,
    CS_DIV8,
    CS_DIV64,
    CS_DIV256,
    CS_DIV1024,
    CS_EXT_FALL,
    CS_EXT_RISE
  } tmr8_clksel_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmr8_bus_req_t;

  typedef struct packed {
    logic compareReq;
    logic overflowReq;
  } tmr8_irq_t;

  typedef struct packed {
    logic [1:0] waveMode;
    logic [1:0] compareOutputMode;
    logic [2:0] clockSelect;
    logic [7:0] counterValue;
    logic [7:0] compareValue;
    logic compareIrqEnable;
    logic overflowIrqEnable;
    logic compareFlag;
    logic overflowFlag;
    logic syncHoldMode;
    logic sharedPrescalerReset;
    logic secondPrescalerReset;
    logic [9:0] prescale;
    logic countDown;
    logic blockMatch;
    logic waveOut;
    logic extSync1;
    logic extSync2;
    logic extPrev;
    logic [7:0] rdata;
  } tmr8_state_t;

endpackage

// ### test/test_tmr8_channel.sv
module test_tmr8_channel;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] cmp;
    int n;
    logic [7:0] cnt;
    logic pin;
    logic ovf;
    logic chk;
  } tmr8_row_t;
  localparam logic [7:0] GEN = tmr8_pkg::GEN_TIMER_CTRL_OFS;
  localparam logic [7:0] CTL = tmr8_pkg::TIMER_CTRL_OFS;
  localparam logic [7:0] CNT = tmr8_pkg::COUNTER_VALUE_OFS;
  localparam logic [7:0] CMP = tmr8_pkg::COMPARE_VALUE_OFS;
  localparam logic [7:0] ENA = tmr8_pkg::IRQ_ENABLE_OFS;
  localparam logic [7:0] FLG = tmr8_pkg::IRQ_FLAG_OFS;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  tmr8_pkg::tmr8_bus_req_t busReq = '0;
  tmr8_pkg::tmr8_irq_t irqReq;
  logic [7:0] busRdata;
  logic cpuGlobalIrqEnable = 1'h0;
  logic extPin = 1'h0;
  logic portDirBit = 1'h0;
  logic slowAck = 1'h0;
  logic compareIrqAck, overflowIrqAck, pin, ovr, oe, second_prescaler_reset;
  logic [7:0] v, e;
  int num_errors = 0, samples_checked = 0, cycles = 0, seed = 32'h0ba7, k;
  logic [7:0] ofs [7] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29};
  int divs [6] = '{0, 1, 8, 64, 256, 1024};
  // counts are ticks from a written zero; chk off where direction state is uncertain
  tmr8_row_t rows [14] = '{
    '{8'h31, 8'h40, 102, 8'h66, 1'h1, 1'h0, 1'h1}, '{8'h21, 8'h40, 102, 8'h66, 1'h0, 1'h0, 1'h1},
    '{8'h11, 8'h40, 102, 8'h66, 1'h1, 1'h0, 1'h1}, '{8'h11, 8'h40, 102, 8'h66, 1'h0, 1'h0, 1'h1},
    '{8'h39, 8'h10, 100, 8'h0F, 1'h1, 1'h0, 1'h1}, '{8'h69, 8'h80, 144, 8'h90, 1'h0, 1'h0, 1'h1},
    '{8'h69, 8'h80, 261, 8'h05, 1'h1, 1'h1, 1'h1}, '{8'h79, 8'h80, 261, 8'h05, 1'h0, 1'h1, 1'h1},
    '{8'h79, 8'h80, 144, 8'h90, 1'h1, 1'h0, 1'h1}, '{8'h79, 8'hFF, 272, 8'h10, 1'h0, 1'h1, 1'h1},
    '{8'h71, 8'h40, 80, 8'h50, 1'h1, 1'h0, 1'h1}, '{8'h71, 8'h40, 462, 8'h30, 1'h0, 1'h0, 1'h1},
    '{8'h61, 8'hFF, 300, 8'hD2, 1'h1, 1'h1, 1'h1}, '{8'h59, 8'h40, 102, 8'h66, 1'h1, 1'h0, 1'h1}};
  always #5 clk = ~clk;
  tmr8_channel dut (.clk, .sys_rst, .busReq, .busRdata, .cpuGlobalIrqEnable, .compareIrqAck,
    .overflowIrqAck, .irqReq, .externalCountPin(extPin), .portDirBit,
    .compareOutputPin(pin), .compareOutputOverride(ovr), .compareOutputOe(oe),
    .secondPrescalerReset(second_prescaler_reset));
  tmr8_cpu_model cpu (.clk, .sys_rst, .slowAck, .irqReq, .compareIrqAck, .overflowIrqAck);
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] w);
    busReq <= '{a, w, 1'h1, 1'h0};
    @(posedge clk);
    busReq.wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic expect_reg(string what, logic [7:0] a, logic [7:0] m, logic [7:0] x);
    busReq <= '{a, 8'h00, 1'h0, 1'h1};
    @(posedge clk);
    busReq.rd <= 1'h0;
    @(posedge clk);
    check(what, x & m, busRdata & m);
  endtask
  // counter runs for n + 2 ticks: the start and stop writes each add one
  task automatic run(logic [7:0] ctl, logic [7:0] x, int n);
    wr(CNT, x);
    wr(CTL, ctl);
    repeat (n) @(posedge clk);
    wr(CTL, ctl & 8'hF8);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    foreach (ofs[i]) expect_reg("reset", ofs[i], 8'hFF, 8'h00);
    v = 8'($random(seed));
    wr(CMP, v);
    expect_reg("compare", CMP, 8'hFF, v);
    wr(CNT, ~v);
    expect_reg("counter", CNT, 8'hFF, ~v);
    wr(ENA, v);
    expect_reg("enables", ENA, 8'h03, v);
    wr(CTL, (v & 8'h78) | 8'h80);
    expect_reg("control", CTL, 8'hFF, v & 8'h78);
    wr(8'h25, v);
    expect_reg("unmapped", 8'h25, 8'hFF, 8'h00);
    wr(GEN, 8'h83);
    expect_reg("sync hold", GEN, 8'h83, 8'h83);
    check("second reset", 8'h01, {7'h00, second_prescaler_reset});
    wr(GEN, 8'h00);
    expect_reg("sync release", GEN, 8'h83, 8'h00);
    wr(GEN, 8'h03);
    expect_reg("self clear", GEN, 8'h83, 8'h00);
    wr(CTL, 8'h00);
    wr(ENA, 8'h00);
    $display("register test done");
    for (int i = 0; i < 2; i++) begin
      v = 8'hF0 | 8'($random(seed) & 15);
      k = 20 + ($random(seed) & 31);
      wr(FLG, 8'h03);
      wr(CMP, v + 8'(i * 3));
      run(8'h01, v, k);
      expect_reg("count", CNT, 8'hFF, 8'(v + k + 2));
      expect_reg("flags", FLG, 8'h03, {6'h00, i[0], 1'h1});
    end
    wr(FLG, 8'h00);
    expect_reg("zero write", FLG, 8'h03, 8'h03);
    wr(FLG, 8'h03);
    expect_reg("one write", FLG, 8'h03, 8'h00);
    foreach (divs[c]) begin
      run(8'(c), 8'h00, 2046);
      e = c ? 8'(2048 / divs[c]) : 8'h00;
      expect_reg("tap stop", CTL, 8'hFF, 8'h00);
      // free-running prescaler: 2048 cycles hold a whole number of tap periods
      expect_reg("tap count", CNT, 8'hFF, e);
    end
    wr(GEN, 8'h81);
    run(8'h03, 8'h00, 300);
    expect_reg("held count", CNT, 8'hFF, 8'h00);
    wr(GEN, 8'h00);
    $display("count test done");
    for (int c = 6; c < 8; c++) begin
      portDirBit <= c[0];
      k = 3 + ($random(seed) & 7);
      wr(CNT, 8'h00);
      wr(CTL, 8'(c));
      repeat (k) begin
        extPin <= 1'h1;
        repeat (3) @(posedge clk);
        extPin <= 1'h0;
        repeat (3) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      wr(CTL, 8'h00);
      expect_reg("edges", CNT, 8'hFF, 8'(k));
    end
    $display("external test done");
    foreach (rows[r]) begin
      portDirBit <= 1'($random(seed));
      wr(CMP, rows[r].cmp);
      wr(FLG, 8'h03);
      run(rows[r].ctl, 8'h00, rows[r].n - 2);
      check("pin", {7'h00, rows[r].pin}, {7'h00, pin});
      check("override", {7'h00, (|rows[r].ctl[5:4])}, {7'h00, ovr});
      check("pin enable", {7'h00, portDirBit & (|rows[r].ctl[5:4])}, {7'h00, oe});
      if (rows[r].chk) begin
        expect_reg("mode count", CNT, 8'hFF, rows[r].cnt);
        expect_reg("overflow", FLG, 8'h01, {7'h00, rows[r].ovf});
      end
    end
    $display("waveform test done");
    wr(ENA, 8'h03);
    wr(CMP, 8'hF8);
    for (int s = 0; s < 2; s++) begin
      slowAck <= s[0];
      cpuGlobalIrqEnable <= 1'h0;
      run(8'h21, 8'hF0, 20);
      check("masked irq", 8'h00, {6'h00, irqReq});
      expect_reg("pending", FLG, 8'h03, 8'h03);
      cpuGlobalIrqEnable <= 1'h1;
      repeat (16) @(posedge clk);
      expect_reg("acked", FLG, 8'h03, 8'h00);
    end
    $display("interrupt test done");
    give_verdict();
  end
endmodule

// ### test/tmr8_channel_properties.sv
module tmr8_channel_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input tmr8_pkg::tmr8_bus_req_t busReq,
  input wire logic [7:0] busRdata,
  input wire logic cpuGlobalIrqEnable,
  input wire logic compareIrqAck,
  input wire logic overflowIrqAck,
  input tmr8_pkg::tmr8_irq_t irqReq,
  input wire logic externalCountPin,
  input wire logic portDirBit,
  input wire logic compareOutputPin,
  input wire logic compareOutputOverride,
  input wire logic compareOutputOe,
  input wire logic secondPrescalerReset
);
  logic genWr;
  assign genWr = busReq.wr && busReq.addr == tmr8_pkg::GEN_TIMER_CTRL_OFS;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_oe_needs_dir: assert property (
    compareOutputOe == (compareOutputOverride && portDirBit)) else $error("pin enable wrong");
  a_mode_takes_pin: assert property (
    busReq.wr && busReq.addr == tmr8_pkg::TIMER_CTRL_OFS |=>
    compareOutputOverride == |$past(busReq.wdata[5:4])) else $error("override wrong");
  a_cmp_req_gated: assert property (
    irqReq.compareReq |-> cpuGlobalIrqEnable) else $error("compare request ungated");
  a_ovf_req_gated: assert property (
    irqReq.overflowReq |-> cpuGlobalIrqEnable) else $error("overflow request ungated");
  a_cmp_ack_clears: assert property (
    compareIrqAck |=> !irqReq.compareReq) else $error("compare ack ignored");
  a_ovf_ack_clears: assert property (
    overflowIrqAck |=> !irqReq.overflowReq) else $error("overflow ack ignored");
  a_psr_self_clear: assert property (
    genWr && !busReq.wdata[7] |=> secondPrescalerReset == $past(busReq.wdata[1])
    ##1 (!secondPrescalerReset || $past(busReq.wr))) else $error("reset bit not cleared");
  a_psr_sync_hold: assert property (
    genWr && busReq.wdata[7] && busReq.wdata[1] ##1 (!busReq.wr) [*3]
    |=> secondPrescalerReset) else $error("reset bit not held");
endmodule

bind tmr8_channel tmr8_channel_properties u_props (.clk, .sys_rst, .busReq, .busRdata,
  .cpuGlobalIrqEnable, .compareIrqAck, .overflowIrqAck, .irqReq, .externalCountPin,
  .portDirBit, .compareOutputPin, .compareOutputOverride, .compareOutputOe,
  .secondPrescalerReset);

// ### test/tmr8_cpu_model.sv
module tmr8_cpu_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic slowAck,
  input tmr8_pkg::tmr8_irq_t irqReq,
  output logic compareIrqAck = 1'h0,
  output logic overflowIrqAck = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] waitCnt_q = 2'h0;
  logic go;
  // one vector at a time, compare first; slow mode lets a few cycles pass
  assign go = !sys_rst && !compareIrqAck && !overflowIrqAck &&
    (irqReq.compareReq || irqReq.overflowReq) && (!slowAck || waitCnt_q == 2'h3);
  always @(posedge clk) begin
    compareIrqAck <= go && irqReq.compareReq;
    overflowIrqAck <= go && !irqReq.compareReq;
    waitCnt_q <= (go || !(irqReq.compareReq || irqReq.overflowReq)) ? 2'h0 : waitCnt_q + 2'h1;
  end
endmodule
